// >>> core/clp_core.sv
// logic cell, debounce, event and irq, pin function mux, apb registers
//
// Operation
// - out_invert set inverts cell result into logic_out
// - input invert bits 5,4,3 invert inputs c, b, a
// - gate_function selects off, and, or, xor, ff, pass a, b, c
// - ff_force_one set forces the cell flip-flop to one unless ff_force_zero is set
// - ff_force_zero set forces the cell flip-flop to zero
// - events from logic_out debounced unless out_debounce_bypass is set
// - out_fifo_event_enable gates events and interrupts from logic_out
// - out_active_sense picks the active level of logic_out
// - row bits set make rows keypad, else general io one higher
// - column bits set make columns keypad, else general io 7 to 11
// - col4_reset_route drives column four with second reset output
// - row4_reset_route drives row four with first reset output
// - row3_alt_route: gpio, logic_in_c input, pwm output, unused
// - row0_alt_route drives row zero with logic_out
// - logic_irq_enable asserts low interrupt while logic flag set
//
// Implementation choice: register access over APB.
`timescale 1ns/1ns
module clp_core (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [5:0] row_in,
    output logic [5:0] row_out,
    output logic [5:0] row_oe_n,
    input wire logic [4:0] col_in,
    output logic [4:0] col_out,
    output logic [4:0] col_oe_n,
    input wire logic [5:0] kp_row_out,
    input wire logic [5:0] kp_row_oe_n,
    output logic [5:0] kp_row_in,
    input wire logic [4:0] kp_col_out,
    input wire logic [4:0] kp_col_oe_n,
    output logic [4:0] kp_col_in,
    input wire logic [10:0] gpio_out,
    input wire logic [10:0] gpio_oe_n,
    output logic [10:0] gpio_in,
    input wire logic logic_in_a,
    input wire logic logic_in_b,
    input wire logic pwm_out,
    input wire logic first_reset_output,
    input wire logic second_reset_output,
    output logic logic_out,
    output logic logic_event_pulse,
    output logic logic_event_level,
    output logic irq_n
);

    ////////////////////////////////////////////////////////////////////////
    // registers and state
    logic [7:0] cell_cfg_reg;
    logic [7:0] ff_ctrl_reg;
    logic [7:0] evt_setup_reg;
    logic [7:0] row_func_reg;
    logic [7:0] col_func_reg;
    logic [7:0] ext_func_reg;
    logic [7:0] irq_en_reg;
    logic [7:0] irq_st_reg;
    logic [31:0] prdata_reg;
    logic [5:0] row_m_reg;
    logic [5:0] row_s_reg;
    logic [4:0] col_m_reg;
    logic [4:0] col_s_reg;
    logic [5:0] row_out_reg;
    logic [5:0] row_oe_n_reg;
    logic [4:0] col_out_reg;
    logic [4:0] col_oe_n_reg;
    logic [5:0] kp_row_in_reg;
    logic [4:0] kp_col_in_reg;
    logic [10:0] gpio_in_reg;
    logic ff_q_reg;
    logic b_prev_reg;
    logic logic_out_reg;
    logic db_reg;
    logic [7:0] db_cnt_reg;
    logic act_prev_reg;
    logic ev_pulse_reg;
    logic ev_level_reg;

    ////////////////////////////////////////////////////////////////////////
    // apb decode
    function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
        hit = (a[11:2] == {2'b00, idx});
    endfunction

    function automatic logic [7:0] wr_val(input logic en, input logic [7:0] d,
                                          input logic [7:0] m, input logic [7:0] q);
        wr_val = en ? (d & m) : q;
    endfunction

    wire s_cfg = hit(paddr, clp_pkg::IDX_CELL_CFG);
    wire s_ff = hit(paddr, clp_pkg::IDX_FF_CTRL);
    wire s_evt = hit(paddr, clp_pkg::IDX_EVT_SETUP);
    wire s_row = hit(paddr, clp_pkg::IDX_ROW_FUNC);
    wire s_col = hit(paddr, clp_pkg::IDX_COL_FUNC);
    wire s_ext = hit(paddr, clp_pkg::IDX_EXT_FUNC);
    wire s_ien = hit(paddr, clp_pkg::IDX_IRQ_EN);
    wire s_ist = hit(paddr, clp_pkg::IDX_IRQ_ST);
    wire mapped = s_cfg | s_ff | s_evt | s_row | s_col | s_ext | s_ien | s_ist;
    wire setup = psel & ~penable;
    wire acc = psel & penable;
    wire wr = acc & pwrite & mapped;
    wire rd_st = acc & ~pwrite & s_ist;
    wire [7:0] rd_mux = ({8{s_cfg}} & cell_cfg_reg)
                      | ({8{s_ff}} & ff_ctrl_reg)
                      | ({8{s_evt}} & evt_setup_reg)
                      | ({8{s_row}} & row_func_reg)
                      | ({8{s_col}} & col_func_reg)
                      | ({8{s_ext}} & ext_func_reg)
                      | ({8{s_ien}} & irq_en_reg)
                      | ({8{s_ist}} & irq_st_reg);

    wire [7:0] cfg_next = wr_val(wr & s_cfg, pwdata[7:0], clp_pkg::WM_CELL_CFG, cell_cfg_reg);
    wire [7:0] ff_next = wr_val(wr & s_ff, pwdata[7:0], clp_pkg::WM_FF_CTRL, ff_ctrl_reg);
    wire [7:0] evt_next = wr_val(wr & s_evt, pwdata[7:0], clp_pkg::WM_EVT_SETUP, evt_setup_reg);
    wire [7:0] row_next = wr_val(wr & s_row, pwdata[7:0], clp_pkg::WM_ROW_FUNC, row_func_reg);
    wire [7:0] col_next = wr_val(wr & s_col, pwdata[7:0], clp_pkg::WM_COL_FUNC, col_func_reg);
    wire [7:0] ext_next = wr_val(wr & s_ext, pwdata[7:0], clp_pkg::WM_EXT_FUNC, ext_func_reg);
    wire [7:0] ien_next = wr_val(wr & s_ien, pwdata[7:0], clp_pkg::WM_IRQ_EN, irq_en_reg);

    assign pready = 1'b1;
    assign pslverr = acc & ~mapped;
    assign prdata = prdata_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cell_cfg_reg <= clp_pkg::RST_VAL;
            ff_ctrl_reg <= clp_pkg::RST_VAL;
            evt_setup_reg <= clp_pkg::RST_VAL;
            row_func_reg <= clp_pkg::RST_VAL;
            col_func_reg <= clp_pkg::RST_VAL;
            ext_func_reg <= clp_pkg::RST_VAL;
            irq_en_reg <= clp_pkg::RST_VAL;
            prdata_reg <= 32'h0;
        end else begin
            cell_cfg_reg <= cfg_next;
            ff_ctrl_reg <= ff_next;
            evt_setup_reg <= evt_next;
            row_func_reg <= row_next;
            col_func_reg <= col_next;
            ext_func_reg <= ext_next;
            irq_en_reg <= ien_next;
            if (setup) begin
                prdata_reg <= {24'h0, rd_mux};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            row_m_reg <= 6'h00;
            row_s_reg <= 6'h00;
            col_m_reg <= 5'h00;
            col_s_reg <= 5'h00;
        end else begin
            row_m_reg <= row_in;
            row_s_reg <= row_m_reg;
            col_m_reg <= col_in;
            col_s_reg <= col_m_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin function mux
    wire [5:0] rk = row_func_reg[5:0];
    wire [4:0] ck = col_func_reg[4:0];
    wire r0_alt = ~rk[0] & ext_func_reg[clp_pkg::B_R0_ALT];
    wire r4_rst = ~rk[4] & ext_func_reg[clp_pkg::B_R4_RST];
    wire c4_rst = ~ck[4] & ext_func_reg[clp_pkg::B_C4_RST];
    wire [1:0] r3_sel = rk[3] ? 2'b00 : ext_func_reg[clp_pkg::B_R3_LO +: 2];
    wire r3_lc = (r3_sel == clp_pkg::R3_LC_IN);
    wire r3_pwm = (r3_sel == clp_pkg::R3_PWM);
    wire r3_off = (r3_sel == clp_pkg::R3_UNUSED);
    wire r3_alt = (r3_sel != clp_pkg::R3_GPIO);
    wire [5:0] r_alt = {1'b0, r4_rst, r3_alt, 2'b00, r0_alt};
    wire [4:0] c_alt = {c4_rst, 4'h0};

    wire [5:0] row_o_d = (rk & kp_row_out) | (~rk & gpio_out[5:0]);
    wire [5:0] row_e_d = (rk & kp_row_oe_n) | (~rk & gpio_oe_n[5:0]);
    wire [4:0] col_o_d = (ck & kp_col_out) | (~ck & gpio_out[10:6]);
    wire [4:0] col_e_d = (ck & kp_col_oe_n) | (~ck & gpio_oe_n[10:6]);

    wire [5:0] row_o_n = {row_o_d[5],
                          r4_rst ? first_reset_output : row_o_d[4],
                          r3_pwm ? pwm_out : row_o_d[3],
                          row_o_d[2:1],
                          r0_alt ? logic_out_reg : row_o_d[0]};
    wire [5:0] row_e_n = {row_e_d[5],
                          r4_rst ? 1'b0 : row_e_d[4],
                          (r3_lc | r3_off) ? 1'b1 : (r3_pwm ? 1'b0 : row_e_d[3]),
                          row_e_d[2:1],
                          r0_alt ? 1'b0 : row_e_d[0]};
    wire [4:0] col_o_n = {c4_rst ? second_reset_output : col_o_d[4], col_o_d[3:0]};
    wire [4:0] col_e_n = {c4_rst ? 1'b0 : col_e_d[4], col_e_d[3:0]};
    wire [10:0] gpio_in_n = {~ck & ~c_alt & col_s_reg, ~rk & ~r_alt & row_s_reg};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            row_out_reg <= 6'h00;
            row_oe_n_reg <= 6'h3f;
            col_out_reg <= 5'h00;
            col_oe_n_reg <= 5'h1f;
            kp_row_in_reg <= 6'h00;
            kp_col_in_reg <= 5'h00;
            gpio_in_reg <= 11'h000;
        end else begin
            row_out_reg <= row_o_n;
            row_oe_n_reg <= row_e_n;
            col_out_reg <= col_o_n;
            col_oe_n_reg <= col_e_n;
            kp_row_in_reg <= rk & row_s_reg;
            kp_col_in_reg <= ck & col_s_reg;
            gpio_in_reg <= gpio_in_n;
        end
    end

    assign row_out = row_out_reg;
    assign row_oe_n = row_oe_n_reg;
    assign col_out = col_out_reg;
    assign col_oe_n = col_oe_n_reg;
    assign kp_row_in = kp_row_in_reg;
    assign kp_col_in = kp_col_in_reg;
    assign gpio_in = gpio_in_reg;

    ////////////////////////////////////////////////////////////////////////
    // logic cell
    wire logic_in_c = r3_lc & row_s_reg[3];
    wire in_a = logic_in_a ^ cell_cfg_reg[clp_pkg::B_INA_INV];
    wire in_b = logic_in_b ^ cell_cfg_reg[clp_pkg::B_INB_INV];
    wire in_c = logic_in_c ^ cell_cfg_reg[clp_pkg::B_INC_INV];
    wire f_one = ff_ctrl_reg[clp_pkg::B_FF_ONE];
    wire f_zero = ff_ctrl_reg[clp_pkg::B_FF_ZERO];
    wire b_rise = in_b & ~b_prev_reg;
    wire ff_d = f_zero ? 1'b0 : (f_one ? 1'b1 : (b_rise ? in_a : ff_q_reg));
    wire clp_pkg::clp_gate_t gsel = clp_pkg::clp_gate_t'(cell_cfg_reg[2:0]);
    logic cell_raw;

    always_comb begin
        case (gsel)
            clp_pkg::GATE_OFF: cell_raw = 1'b0;
            clp_pkg::GATE_AND: cell_raw = in_a & in_b & in_c;
            clp_pkg::GATE_OR: cell_raw = in_a | in_b | in_c;
            clp_pkg::GATE_XOR: cell_raw = in_a ^ in_b ^ in_c;
            clp_pkg::GATE_FF: cell_raw = ff_q_reg;
            clp_pkg::GATE_PA: cell_raw = in_a;
            clp_pkg::GATE_PB: cell_raw = in_b;
            clp_pkg::GATE_PC: cell_raw = in_c;
            default: cell_raw = 1'b0;
        endcase
    end

    wire logic_out_next = cell_raw ^ cell_cfg_reg[clp_pkg::B_OUT_INV];
    assign logic_out = logic_out_reg;

    ////////////////////////////////////////////////////////////////////////
    // debounce, event and interrupt
    localparam logic [7:0] DB_LAST = 8'(clp_pkg::DBNC_CYC - 1);
    wire byp = evt_setup_reg[clp_pkg::B_DBNC_BYP];
    wire ev_en = evt_setup_reg[clp_pkg::B_EVT_EN];
    wire sense = evt_setup_reg[clp_pkg::B_SENSE];
    wire db_diff = logic_out_reg ^ db_reg;
    wire db_done = db_diff & (db_cnt_reg == DB_LAST);
    wire filt = byp ? logic_out_reg : db_reg;
    wire act = ~(filt ^ sense);
    wire act_rise = act & ~act_prev_reg & ev_en;
    wire [7:0] st_set = {3'b000, act_rise, 4'h0};
    wire [7:0] st_clr = rd_st ? prdata_reg[7:0] : 8'h00;
    wire [7:0] st_next = st_set | (irq_st_reg & ~st_clr);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ff_q_reg <= 1'b0;
            b_prev_reg <= 1'b0;
            logic_out_reg <= 1'b0;
            db_reg <= 1'b0;
            db_cnt_reg <= 8'h00;
            act_prev_reg <= 1'b0;
            ev_pulse_reg <= 1'b0;
            ev_level_reg <= 1'b0;
            irq_st_reg <= 8'h00;
        end else begin
            ff_q_reg <= ff_d;
            b_prev_reg <= in_b;
            logic_out_reg <= logic_out_next;
            db_reg <= db_done ? logic_out_reg : db_reg;
            db_cnt_reg <= (db_diff & ~db_done) ? db_cnt_reg + 8'h01 : 8'h00;
            act_prev_reg <= act;
            ev_pulse_reg <= act_rise;
            ev_level_reg <= act_rise ? filt : ev_level_reg;
            irq_st_reg <= st_next;
        end
    end

    assign logic_event_pulse = ev_pulse_reg;
    assign logic_event_level = ev_level_reg;
    assign irq_n = ~|(irq_st_reg & irq_en_reg);

    ////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    out_invert_a: assert property (
        ##1 logic_out_reg == ($past(cell_raw) ^ $past(cell_cfg_reg[6])))
        else $error("logic_out inversion wrong");
    in_invert_a: assert property (
        gsel == clp_pkg::GATE_PA |=> logic_out_reg == $past(logic_in_a ^ cell_cfg_reg[3] ^ cell_cfg_reg[6]))
        else $error("input a inversion wrong");
    gate_and_a: assert property (
        gsel == clp_pkg::GATE_AND && !cell_cfg_reg[6] |=> logic_out_reg == $past(in_a & in_b & in_c))
        else $error("and gate wrong");
    gate_off_a: assert property (
        gsel == clp_pkg::GATE_OFF |=> logic_out_reg == $past(cell_cfg_reg[6]))
        else $error("off gate wrong");
    ff_one_a: assert property (
        f_one && !f_zero |=> ff_q_reg)
        else $error("ff force one ignored");
    ff_zero_a: assert property (
        f_zero |=> !ff_q_reg)
        else $error("ff force zero ignored");
    ff_clock_a: assert property (
        !f_one && !f_zero && !b_rise |=> ff_q_reg == $past(ff_q_reg))
        else $error("ff changed without clock");
    dbnc_wait_a: assert property (
        $changed(db_reg) |-> $past(db_cnt_reg) == DB_LAST)
        else $error("debounce settled early");
    dbnc_byp_a: assert property (
        byp |-> filt == logic_out_reg)
        else $error("debounce bypass ignored");
    event_gate_a: assert property (
        !ev_en |=> !logic_event_pulse && irq_st_reg[4] <= $past(irq_st_reg[4]))
        else $error("event while disabled");
    sense_level_a: assert property (
        logic_event_pulse |-> logic_event_level == $past(sense))
        else $error("event on wrong level");
    row_kp_a: assert property (
        rk[1] |=> row_out[1] == $past(kp_row_out[1]))
        else $error("row keypad route wrong");
    col_gpio_a: assert property (
        !ck[2] |=> col_out[2] == $past(gpio_out[8]))
        else $error("column gpio route wrong");
    col4_rst_a: assert property (
        c4_rst |=> col_out[4] == $past(second_reset_output) && !col_oe_n[4])
        else $error("column four reset route wrong");
    row4_rst_a: assert property (
        r4_rst |=> row_out[4] == $past(first_reset_output) && !row_oe_n[4])
        else $error("row four reset route wrong");
    row3_pwm_a: assert property (
        r3_pwm |=> row_out[3] == $past(pwm_out) && !row_oe_n[3])
        else $error("row three pwm route wrong");
    row0_alt_a: assert property (
        r0_alt |=> row_out[0] == $past(logic_out_reg))
        else $error("row zero logic route wrong");
    irq_pin_a: assert property (
        irq_st_reg[4] && irq_en_reg[4] |-> !irq_n)
        else $error("interrupt pin not asserted");
    base_wins_a: assert property (
        rk[0] |=> row_out[0] == $past(kp_row_out[0]))
        else $error("alternate overrode keypad");

    ev_seen_c: cover property (logic_event_pulse ##[1:20] !irq_n);
    ff_mode_c: cover property (gsel == clp_pkg::GATE_FF && b_rise);
    st_clear_c: cover property (rd_st && irq_st_reg[4] ##1 !irq_st_reg[4]);
    dbnc_c: cover property (!byp && $changed(db_reg));

endmodule

// >>> core/clp_pkg.sv
// constants and types for the logic cell and pin function mux
package clp_pkg;

    localparam int CLK_MHZ = 125;
    localparam int DBNC_TIME_NS = 1000;
    localparam int DBNC_CYC = (DBNC_TIME_NS * CLK_MHZ + 999) / 1000;

    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_CELL_CFG = 8'h34;
    localparam logic [7:0] IDX_FF_CTRL = 8'h35;
    localparam logic [7:0] IDX_EVT_SETUP = 8'h36;
    localparam logic [7:0] IDX_ROW_FUNC = 8'h38;
    localparam logic [7:0] IDX_COL_FUNC = 8'h39;
    localparam logic [7:0] IDX_EXT_FUNC = 8'h3a;
    localparam logic [7:0] IDX_IRQ_EN = 8'h3c;
    localparam logic [7:0] IDX_IRQ_ST = 8'h3d;

    // writable bits of each register except the irq status register, then the common reset value
    localparam logic [7:0] WM_CELL_CFG = 8'h7f;
    localparam logic [7:0] WM_FF_CTRL = 8'hff;
    localparam logic [7:0] WM_EVT_SETUP = 8'h07;
    localparam logic [7:0] WM_ROW_FUNC = 8'h3f;
    localparam logic [7:0] WM_COL_FUNC = 8'h1f;
    localparam logic [7:0] WM_EXT_FUNC = 8'hed;
    localparam logic [7:0] WM_IRQ_EN = 8'h10;
    localparam logic [7:0] RST_VAL = 8'h00;

    // field positions
    localparam int B_OUT_INV = 6;
    localparam int B_INC_INV = 5;
    localparam int B_INB_INV = 4;
    localparam int B_INA_INV = 3;
    localparam int B_FF_ONE = 1;
    localparam int B_FF_ZERO = 0;
    localparam int B_DBNC_BYP = 2;
    localparam int B_EVT_EN = 1;
    localparam int B_SENSE = 0;
    localparam int B_C4_RST = 6;
    localparam int B_R4_RST = 5;
    localparam int B_R3_LO = 2;
    localparam int B_R0_ALT = 0;
    localparam int B_LOGIC_IRQ = 4;

    typedef enum logic [2:0] {
        GATE_OFF = 3'b000,
        GATE_AND = 3'b001,
        GATE_OR = 3'b010,
        GATE_XOR = 3'b011,
        GATE_FF = 3'b100,
        GATE_PA = 3'b101,
        GATE_PB = 3'b110,
        GATE_PC = 3'b111
    } clp_gate_t;

    typedef enum logic [1:0] {
        R3_GPIO = 2'b00,
        R3_LC_IN = 2'b01,
        R3_PWM = 2'b10,
        R3_UNUSED = 2'b11
    } clp_r3_t;

endpackage

// >>> tb/clp_pins.sv
// far-side pin model: wire level from design drive or external driver
`timescale 1ns/1ns
module clp_pins (
    input wire logic [5:0] row_out,
    input wire logic [5:0] row_oe_n,
    input wire logic [4:0] col_out,
    input wire logic [4:0] col_oe_n,
    input wire logic [5:0] ext_row,
    input wire logic [4:0] ext_col,
    output logic [5:0] row_in,
    output logic [4:0] col_in
);
    assign row_in = (row_oe_n & ext_row) | (~row_oe_n & row_out);
    assign col_in = (col_oe_n & ext_col) | (~col_oe_n & col_out);
endmodule

// >>> tb/clp_core_test.sv
// self-checking bench for the logic cell and pin function mux
`timescale 1ns/1ns
module clp_core_test;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0] row_in, row_out, row_oe_n, kp_row_out, kp_row_oe_n, kp_row_in, ext_row;
    logic [4:0] col_in, col_out, col_oe_n, kp_col_out, kp_col_oe_n, kp_col_in, ext_col;
    logic [10:0] gpio_out, gpio_oe_n, gpio_in;
    logic logic_in_a, logic_in_b, pwm_out, first_reset_output, second_reset_output;
    logic logic_out, logic_event_pulse, logic_event_level, irq_n, er;
    logic [31:0] seed = 32'h74245458;
    int num_errors = 0, checked = 0, cycles = 0, pulses = 0;
    logic [7:0] ridx [8] = '{clp_pkg::IDX_CELL_CFG, clp_pkg::IDX_FF_CTRL, clp_pkg::IDX_EVT_SETUP,
        clp_pkg::IDX_ROW_FUNC, clp_pkg::IDX_COL_FUNC, clp_pkg::IDX_EXT_FUNC, clp_pkg::IDX_IRQ_EN, clp_pkg::IDX_IRQ_ST};
    logic [7:0] rwm [7] = '{clp_pkg::WM_CELL_CFG, clp_pkg::WM_FF_CTRL, clp_pkg::WM_EVT_SETUP,
        clp_pkg::WM_ROW_FUNC, clp_pkg::WM_COL_FUNC, clp_pkg::WM_EXT_FUNC, clp_pkg::WM_IRQ_EN};

    clp_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .row_in(row_in), .row_out(row_out), .row_oe_n(row_oe_n), .col_in(col_in), .col_out(col_out),
        .col_oe_n(col_oe_n), .kp_row_out(kp_row_out), .kp_row_oe_n(kp_row_oe_n), .kp_row_in(kp_row_in),
        .kp_col_out(kp_col_out), .kp_col_oe_n(kp_col_oe_n), .kp_col_in(kp_col_in), .gpio_out(gpio_out),
        .gpio_oe_n(gpio_oe_n), .gpio_in(gpio_in), .logic_in_a(logic_in_a), .logic_in_b(logic_in_b),
        .pwm_out(pwm_out), .first_reset_output(first_reset_output),
        .second_reset_output(second_reset_output), .logic_out(logic_out),
        .logic_event_pulse(logic_event_pulse), .logic_event_level(logic_event_level), .irq_n(irq_n));
    clp_pins pins (.row_out(row_out), .row_oe_n(row_oe_n), .col_out(col_out), .col_oe_n(col_oe_n),
        .ext_row(ext_row), .ext_col(ext_col), .row_in(row_in), .col_in(col_in));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task end_of_test();
        if (num_errors == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // hang guard and event pulse count
    always @(posedge pclk) begin
        cycles++;
        if (logic_event_pulse === 1'b1) pulses++;
        if (cycles == 40000) begin
            num_errors++;
            end_of_test();
        end
    end

    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one apb transfer, then one idle cycle
    task apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task wait_n(input int n);
        repeat (n) @(posedge pclk);
    endtask

    function logic cell_exp(input logic [7:0] c, input logic a, input logic b, input logic lc);
        logic x, y, z, r;
        x = a ^ c[3];
        y = b ^ c[4];
        z = lc ^ c[5];
        case (c[2:0])
            3'b001: r = x & y & z;
            3'b010: r = x | y | z;
            3'b011: r = x ^ y ^ z;
            3'b101: r = x;
            3'b110: r = y;
            3'b111: r = z;
            default: r = 1'b0;
        endcase
        return r ^ c[6];
    endfunction

    // one event trial: raise logic_in_a for hold cycles, then check status and irq
    task evt_try(input logic [7:0] setup, input logic [7:0] ien, input int hold, input logic hit, input logic irq);
        apb(1'b1, clp_pkg::IDX_EVT_SETUP, setup);
        apb(1'b1, clp_pkg::IDX_IRQ_EN, ien);
        apb(1'b0, clp_pkg::IDX_IRQ_ST, 8'h00);
        pulses = 0;
        logic_in_a <= 1'b1;
        wait_n(hold);
        logic_in_a <= 1'b0;
        wait_n(140);
        chk("irq_n", irq_n, !irq);
        chk("event pulses", pulses, hit);
        if (hit) chk("event level", logic_event_level, setup[0]);
        apb(1'b0, clp_pkg::IDX_IRQ_ST, 8'h00);
        chk("irq status", rd, {hit, 4'h0});
        chk("irq_n cleared", irq_n, 1'b1);
    endtask

    // pin routing trial with the given function registers
    task pin_try(input logic [7:0] rf, input logic [7:0] cf, input logic [7:0] ef);
        logic [31:0] s, t;
        logic [10:0] f, oe, ou, gi, ki, lvl, ex;
        logic gm;
        s = rnd();
        t = rnd();
        apb(1'b1, clp_pkg::IDX_ROW_FUNC, rf);
        apb(1'b1, clp_pkg::IDX_COL_FUNC, cf);
        apb(1'b1, clp_pkg::IDX_EXT_FUNC, ef);
        apb(1'b1, clp_pkg::IDX_CELL_CFG, {1'b0, s[31], 6'h0});
        {second_reset_output, gpio_oe_n, gpio_out} <= s[22:0];
        {first_reset_output, pwm_out, kp_row_out} <= s[30:23];
        {ext_col, ext_row, kp_col_oe_n, kp_col_out, kp_row_oe_n} <= t[26:0];
        wait_n(8);
        f = {cf[4:0], rf[5:0]};
        ex = {ext_col, ext_row};
        for (int i = 0; i < 11; i++) begin
            gm = 1'b0;
            if (f[i]) {oe[i], ou[i]} = {kp_col_oe_n[i - 6 * (i / 6)] & (i > 5) | kp_row_oe_n[i % 6] & (i < 6),
                                        kp_col_out[i - 6 * (i / 6)] & (i > 5) | kp_row_out[i % 6] & (i < 6)};
            else if (i == 0 && ef[0]) {oe[i], ou[i]} = {1'b0, s[31]};
            else if (i == 4 && ef[5]) {oe[i], ou[i]} = {1'b0, first_reset_output};
            else if (i == 3 && ef[3:2] != 2'b00) {oe[i], ou[i]} = {ef[3:2] != 2'b10, pwm_out};
            else if (i == 10 && ef[6]) {oe[i], ou[i]} = {1'b0, second_reset_output};
            else begin
                {oe[i], ou[i]} = {gpio_oe_n[i], gpio_out[i]};
                gm = 1'b1;
            end
            lvl[i] = oe[i] ? ex[i] : ou[i];
            gi[i] = gm & lvl[i];
            ki[i] = f[i] & lvl[i];
        end
        chk("pin enables", {col_oe_n, row_oe_n}, oe);
        chk("pin levels", {col_out, row_out} & ~oe, ou & ~oe);
        chk("gpio_in", gpio_in, gi);
        chk("keypad in", {kp_col_in, kp_row_in}, ki);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] c;
        logic lc;
        logic [31:0] r;
        {presetn, psel, penable, pwrite, paddr, pwdata, logic_in_a, logic_in_b} = '0;
        {kp_row_out, kp_row_oe_n, kp_col_out, kp_col_oe_n, ext_row, ext_col} = '0;
        {gpio_out, gpio_oe_n, pwm_out, first_reset_output, second_reset_output} = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset values, access masks, unmapped place
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, ridx[i], 8'h00);
            chk("reset value", rd, clp_pkg::RST_VAL);
        end
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, ridx[i], 8'hff);
            apb(1'b0, ridx[i], 8'h00);
            chk("write mask", rd, rwm[i]);
            chk("mapped error", er, 1'b0);
        end
        apb(1'b0, 8'h37, 8'h00);
        chk("unmapped error", er, 1'b1);
        chk("unmapped data", rd, 32'h0);
        for (int i = 0; i < 7; i++) apb(1'b1, ridx[i], 8'h00);
        // cell functions with random inputs and inversions
        apb(1'b1, clp_pkg::IDX_EXT_FUNC, 8'h04);
        for (int i = 0; i < 32; i++) begin
            r = rnd();
            c = {1'b0, r[6:3], (i[2:0] == 3'b100) ? 3'b000 : i[2:0]};
            lc = (c[2:0] == 3'b001) ? 1'b1 : (c[2:1] == 2'b01) ? 1'b0 : r[10];
            apb(1'b1, clp_pkg::IDX_CELL_CFG, c);
            logic_in_a <= r[8];
            logic_in_b <= r[9];
            ext_row[3] <= lc ^ c[5];
            wait_n(6);
            chk("logic_out", logic_out, cell_exp(c, r[8], r[9], lc ^ c[5]));
        end
        // flip-flop mode, forces and edge capture
        {logic_in_a, logic_in_b} <= 2'b00;
        apb(1'b1, clp_pkg::IDX_CELL_CFG, 8'h04);
        apb(1'b1, clp_pkg::IDX_FF_CTRL, 8'h02);
        wait_n(2);
        chk("ff force one", logic_out, 1'b1);
        apb(1'b1, clp_pkg::IDX_FF_CTRL, 8'h03);
        wait_n(2);
        chk("ff force zero", logic_out, 1'b0);
        apb(1'b1, clp_pkg::IDX_FF_CTRL, 8'h00);
        logic_in_a <= 1'b1;
        wait_n(4);
        logic_in_b <= 1'b1;
        wait_n(4);
        chk("ff capture one", logic_out, 1'b1);
        logic_in_a <= 1'b0;
        wait_n(4);
        chk("ff holds", logic_out, 1'b1);
        logic_in_b <= 1'b0;
        wait_n(4);
        logic_in_b <= 1'b1;
        wait_n(4);
        chk("ff capture zero", logic_out, 1'b0);
        // events and interrupt through pass-a cell
        apb(1'b1, clp_pkg::IDX_CELL_CFG, 8'h05);
        evt_try(8'h07, 8'h10, 3, 1'b1, 1'b1);
        evt_try(8'h03, 8'h10, 60, 1'b0, 1'b0);
        evt_try(8'h03, 8'h10, 140, 1'b1, 1'b1);
        evt_try(8'h06, 8'h10, 3, 1'b1, 1'b1);
        evt_try(8'h05, 8'h10, 3, 1'b0, 1'b0);
        evt_try(8'h07, 8'h00, 3, 1'b1, 1'b0);
        // pin routing: hand corners then random
        pin_try(8'h00, 8'h00, 8'h69);
        pin_try(8'h3f, 8'h1f, 8'h6d);
        pin_try(8'h00, 8'h00, 8'h0c);
        for (int i = 0; i < 30; i++) begin
            rd = rnd();
            pin_try(rd[7:0] & 8'h3f, rd[15:8] & 8'h1f, rd[23:16] & 8'hed);
        end
        end_of_test();
    end
endmodule
